// ==== design/terminal_call_control.sv ====
`timescale 1ns/1ps

module terminal_call_control
  import call_ctrl_pkg::*;
#(
  parameter int CLEAR_LIMIT    = CLEAR_CYCLES,
  parameter int DEBOUNCE_LIMIT = DEBOUNCE_CYCLES
)
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              test_button,
  input  wire logic              clear_button,
  input  wire logic              answer_button,
  input  wire logic              orig_button,
  input  wire logic              local_button,
  input  wire logic              break_button,
  input  wire logic              ring_in,
  input  wire logic              hold_off_signal,
  input  wire logic              conv_break_in,
  input  wire logic              copy_mode,
  input  wire logic              paper_low,
  input  wire logic              out_of_service,
  input  wire logic              forms_feed,
  input  wire logic              eot_code,
  input  wire logic              rx_data_in,
  input  wire logic              tx_data_in,
  output logic                   loop_test_lamp,
  output logic                   print_data,
  output logic                   modulator_data,
  output logic                   spacing_disc_enable,
  output logic                   break_release_lamp,
  output logic                   hold_off_lamp,
  output logic                   clear_lamp,
  output logic                   reply_button_lamp,
  output logic                   tx_brk_held,
  output logic                   recv_brk_normal_held,
  output logic                   line_seized,
  output logic                   reply_out
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] meta_q;
  logic [NUM_IN-1:0] sync_q;
  logic [NUM_IN-1:0] db_q;
  logic [NUM_IN-1:0] prev_q;
  logic [NUM_IN-1:0] rise;
  logic [1:0]        rxd_meta_q;
  logic [1:0]        txd_meta_q;

  assign raw_in = {eot_code, forms_feed, out_of_service, paper_low, copy_mode,
                   conv_break_in, hold_off_signal, ring_in, break_button,
                   local_button, orig_button, answer_button, clear_button,
                   test_button};

  genvar gi;
  for (gi = 0; gi < NUM_IN; gi++)
  begin : g_in
    logic [DB_W-1:0] cnt_q;
    always_ff @(posedge mclk)
    begin
      if (srst)
      begin
        meta_q[gi] <= 1'b0;
        sync_q[gi] <= 1'b0;
        db_q[gi]   <= 1'b0;
        cnt_q      <= '0;
      end
      else
      begin
        meta_q[gi] <= raw_in[gi];
        sync_q[gi] <= meta_q[gi];
        // Contact bounce must stay stable for the whole window
        if (sync_q[gi] == db_q[gi])
        begin
          cnt_q <= '0;
        end
        else if (cnt_q == DB_W'(DEBOUNCE_LIMIT - 1))
        begin
          db_q[gi] <= sync_q[gi];
          cnt_q    <= '0;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // Serial data is only synchronised; debouncing would eat bits
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rxd_meta_q <= 2'b11;
      txd_meta_q <= 2'b11;
      prev_q     <= '0;
    end
    else
    begin
      rxd_meta_q <= {rxd_meta_q[0], rx_data_in};
      txd_meta_q <= {txd_meta_q[0], tx_data_in};
      prev_q     <= db_q;
    end
  end

  assign rise = db_q & ~prev_q;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [1:0]      ctrl_q;
  logic            wait_q;
  logic [31:0]     rdata_q;
  logic [ST_W-1:0] status;
  logic            bus_req;
  logic            bus_done;

  assign bus_req  = avs_read | avs_write;
  assign bus_done = bus_req & ~wait_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= ~(bus_req & wait_q);
      if (bus_req & wait_q)
      begin
        unique case (avs_address)
          ADDR_CTRL: rdata_q <= {30'h0000_0000, ctrl_q};
          ADDR_STAT: rdata_q <= {21'h00_0000, status};
          default:   rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (bus_done && avs_write && avs_address == ADDR_CTRL)
    begin
      ctrl_q <= avs_writedata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Call state
  // ----------------------------------------------------------------
  logic var_b;
  logic test_q;
  logic local_q;
  logic orig_q;
  logic reply_q;
  logic rx_brk_q;
  logic tclr_q;
  logic rrp_q;
  logic rx_held_q;
  logic tx_held_q;
  logic txclr_q;
  logic seized_q;
  logic auto_ok;
  logic ring;
  logic clr_rise;
  logic mode_a;
  logic tm_run;
  logic tm_done;
  logic [TIMER_W-1:0] tm_q;

  assign var_b    = ctrl_q[CTRL_VARB];
  assign ring     = db_q[IN_RING];
  assign clr_rise = rise[IN_CLEAR];
  assign mode_a   = reply_q | orig_q;

  assign auto_ok = ctrl_q[CTRL_AUTO] & ~db_q[IN_COPY] & ~local_q & ~orig_q
                 & ~test_q & ~db_q[IN_PAPER] & ~db_q[IN_OOS]
                 & ~db_q[IN_FORMS];

  assign status = {local_q, seized_q, txclr_q, tx_held_q, rx_held_q, rrp_q,
                   orig_q, reply_q, tclr_q, rx_brk_q, test_q};

  // One timer serves both variants; they never run together
  assign tm_run  = var_b ? (txclr_q & seized_q) : tclr_q;
  assign tm_done = tm_run && tm_q == TIMER_W'(CLEAR_LIMIT - 1);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tm_q <= '0;
    end
    else if (tm_run && !tm_done)
    begin
      tm_q <= tm_q + 1'b1;
    end
    else
    begin
      tm_q <= '0;
    end
  end

  // Loop test and local selection
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      test_q  <= 1'b0;
      local_q <= 1'b0;
    end
    else
    begin
      if (rise[IN_TEST])
      begin
        test_q <= 1'b1;
      end
      else if (|rise[IN_BREAK:IN_CLEAR])
      begin
        test_q <= 1'b0;
      end
      if (rise[IN_LOCAL])
      begin
        local_q <= 1'b1;
      end
      else if (rise[IN_ORIG] || rise[IN_ANSWER])
      begin
        local_q <= 1'b0;
      end
    end
  end

  // Originate mode, kept only as far as clear and answer need it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      orig_q <= 1'b0;
    end
    else if (tm_done)
    begin
      orig_q <= 1'b0;
    end
    else if (rise[IN_ORIG] && !reply_q && !seized_q)
    begin
      orig_q <= 1'b1;
    end
  end

  // Variant A latches
  always_ff @(posedge mclk)
  begin
    if (srst || var_b)
    begin
      reply_q  <= 1'b0;
      rx_brk_q <= 1'b0;
      tclr_q   <= 1'b0;
    end
    else
    begin
      if (tm_done)
      begin
        reply_q <= 1'b0;
      end
      else if ((ring && auto_ok) || rise[IN_ANSWER])
      begin
        reply_q <= 1'b1;
      end
      if (!mode_a || tm_done)
      begin
        rx_brk_q <= 1'b0;
      end
      else if (clr_rise)
      begin
        rx_brk_q <= 1'b1;
      end
      // Timed clear follows receive-break, or end of transmission
      if (!mode_a || tm_done)
      begin
        tclr_q <= 1'b0;
      end
      else if (rx_brk_q || rise[IN_EOT])
      begin
        tclr_q <= 1'b1;
      end
    end
  end

  // Variant B latches
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rrp_q     <= 1'b0;
      rx_held_q <= 1'b1;
      tx_held_q <= 1'b1;
      txclr_q   <= 1'b0;
      seized_q  <= 1'b0;
    end
    else if (!var_b)
    begin
      rrp_q     <= 1'b0;
      rx_held_q <= 1'b1;
      tx_held_q <= 1'b1;
      txclr_q   <= 1'b0;
      seized_q  <= 1'b0;
    end
    else
    begin
      if (txclr_q && !seized_q)
      begin
        rrp_q <= 1'b0;
      end
      else if ((clr_rise && rx_held_q) || (rise[IN_EOT] && seized_q))
      begin
        rrp_q <= 1'b1;
      end
      rx_held_q <= ~rrp_q & ~txclr_q;
      tx_held_q <= ~rrp_q & ~txclr_q;
      // Clear latch bridges the line hold once the break releases
      if (!seized_q && txclr_q)
      begin
        txclr_q <= 1'b0;
      end
      else if (rrp_q)
      begin
        txclr_q <= 1'b1;
      end
      if (tm_done || !(tx_held_q || txclr_q))
      begin
        seized_q <= 1'b0;
      end
      else if ((ring && auto_ok) || (rise[IN_ANSWER] && !orig_q))
      begin
        seized_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      loop_test_lamp      <= 1'b0;
      print_data          <= 1'b1;
      modulator_data      <= 1'b1;
      spacing_disc_enable <= 1'b0;
    end
    else
    begin
      loop_test_lamp      <= test_q;
      print_data          <= rxd_meta_q[1];
      modulator_data      <= test_q ? rxd_meta_q[1] : txd_meta_q[1];
      spacing_disc_enable <= ~test_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      break_release_lamp <= 1'b0;
      hold_off_lamp      <= 1'b0;
    end
    else
    begin
      break_release_lamp <= db_q[IN_CONV] | (var_b ? (rrp_q & tx_held_q)
                                                  : (rx_brk_q & ~tclr_q));
      hold_off_lamp      <= db_q[IN_HOLD] | db_q[IN_CONV];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      clear_lamp        <= 1'b0;
      reply_button_lamp <= 1'b0;
    end
    else
    begin
      clear_lamp        <= var_b ? (txclr_q & seized_q) : tclr_q;
      reply_button_lamp <= ring | (var_b ? (seized_q & ~txclr_q & ~orig_q)
                                         : (reply_q & ~tclr_q));
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tx_brk_held          <= 1'b0;
      recv_brk_normal_held <= 1'b0;
      line_seized          <= 1'b0;
      reply_out            <= 1'b0;
    end
    else
    begin
      tx_brk_held          <= var_b & tx_held_q;
      recv_brk_normal_held <= var_b & rx_held_q;
      line_seized          <= var_b ? seized_q : mode_a;
      reply_out            <= reply_q;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule : terminal_call_control

// ==== design/call_ctrl_pkg.sv ====
package call_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 25_000_000;
  localparam int CLEAR_TIME_MS    = 700;
  localparam int CLEAR_CYCLES     = CLEAR_TIME_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_TIME_MS = 10;
  localparam int DEBOUNCE_CYCLES  = DEBOUNCE_TIME_MS * (CLK_HZ / 1000);
  localparam int TIMER_W          = 25;
  localparam int DB_W             = 18;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_STAT  = 4'h4;
  localparam int         CTRL_VARB  = 0;
  localparam int         CTRL_AUTO  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // Status bit positions
  localparam int ST_TEST   = 0;
  localparam int ST_RXBRK  = 1;
  localparam int ST_TCLR   = 2;
  localparam int ST_REPLY  = 3;
  localparam int ST_ORIG   = 4;
  localparam int ST_RRP    = 5;
  localparam int ST_RXHELD = 6;
  localparam int ST_TXHELD = 7;
  localparam int ST_TXCLR  = 8;
  localparam int ST_SEIZED = 9;
  localparam int ST_LOCAL  = 10;
  localparam int ST_W      = 11;

  // ----------------------------------------------------------------
  // Debounced input indices
  // ----------------------------------------------------------------
  localparam int IN_TEST   = 0;
  localparam int IN_CLEAR  = 1;
  localparam int IN_ANSWER = 2;
  localparam int IN_ORIG   = 3;
  localparam int IN_LOCAL  = 4;
  localparam int IN_BREAK  = 5;
  localparam int IN_RING   = 6;
  localparam int IN_HOLD   = 7;
  localparam int IN_CONV   = 8;
  localparam int IN_COPY   = 9;
  localparam int IN_PAPER  = 10;
  localparam int IN_OOS    = 11;
  localparam int IN_FORMS  = 12;
  localparam int IN_EOT    = 13;
  localparam int NUM_IN    = 14;

endpackage : call_ctrl_pkg

// ==== tb/coupler_model.sv ====
`timescale 1ns/1ps
module coupler_model
  import call_ctrl_pkg::*;
#(
  parameter int LAG = 2
)
(
  input  wire logic mclk,
  input  wire logic ring_req,
  input  wire logic hold_req,
  input  wire logic conv_req,
  input  wire logic rx_bit,
  output logic      ring_in,
  output logic      hold_off_signal,
  output logic      conv_break_in,
  output logic      rx_data_in
);
  // ------
  // Line delay
  // ------
  // Idle line by default: no ring, hold or break, data at mark
  logic [3:0] pipe_q [0:7] = '{default: 4'h1};

  always @(posedge mclk)
  begin
    pipe_q[0] <= {ring_req, hold_req, conv_req, rx_bit};
    for (int i = 1; i < 8; i++)
      pipe_q[i] <= pipe_q[i - 1];
  end

  assign {ring_in, hold_off_signal, conv_break_in, rx_data_in} = pipe_q[LAG];
endmodule : coupler_model

// ==== tb/terminal_call_control_monitor.sv ====
`timescale 1ns/1ps
module call_ctrl_monitor
  import call_ctrl_pkg::*;
#(
  parameter int CLEAR_LIMIT    = 20,
  parameter int DEBOUNCE_LIMIT = 4
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic ring_in,
  input wire logic hold_off_signal,
  input wire logic loop_test_lamp,
  input wire logic print_data,
  input wire logic modulator_data,
  input wire logic spacing_disc_enable,
  input wire logic break_release_lamp,
  input wire logic hold_off_lamp,
  input wire logic clear_lamp,
  input wire logic reply_button_lamp,
  input wire logic tx_brk_held,
  input wire logic recv_brk_normal_held,
  input wire logic line_seized
);
  logic [31:0] lit_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // ------
  // Clear lamp on-time
  // ------
  always_ff @(posedge mclk)
    lit_q <= (srst || !clear_lamp) ? 32'h0000_0000 : lit_q + 32'h0000_0001;

  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  AST_TEST_SPACING: assert property (loop_test_lamp |-> !spacing_disc_enable)
    else $error("spacing disconnect in test");
  AST_TEST_LOOPBACK: assert property (loop_test_lamp && $past(loop_test_lamp) |-> modulator_data == print_data)
    else $error("no loopback in test");
  AST_HOLD_LAMP: assert property ($rose(hold_off_signal) ##1 hold_off_signal[*8] |-> ##[0:4] hold_off_lamp)
    else $error("hold-off lamp late");
  AST_CLEAR_MAX: assert property (lit_q <= CLEAR_LIMIT + 4)
    else $error("clear lamp too long");
  AST_CLEAR_MIN: assert property ($fell(clear_lamp) |-> $past(lit_q) >= CLEAR_LIMIT - 3)
    else $error("clear lamp too short");
  AST_BRK_LAMP_OFF: assert property (clear_lamp && $past(clear_lamp) && !hold_off_lamp |-> !break_release_lamp)
    else $error("break lamp held in clear");
  AST_REPLY_LAMP_OFF: assert property (clear_lamp && !ring_in && !$past(ring_in, 8) |-> !reply_button_lamp)
    else $error("answer lamp lit in clear");
  AST_HELD_RELEASED: assert property (clear_lamp |-> !tx_brk_held && !recv_brk_normal_held)
    else $error("held signals in clear");
  AST_CLEAR_SEIZED: assert property ($rose(clear_lamp) |-> line_seized)
    else $error("clear lamp without call");
endmodule : call_ctrl_monitor

bind terminal_call_control call_ctrl_monitor #(.CLEAR_LIMIT(CLEAR_LIMIT), .DEBOUNCE_LIMIT(DEBOUNCE_LIMIT))
  u_call_ctrl_monitor (.mclk(mclk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .ring_in(ring_in), .hold_off_signal(hold_off_signal),
  .loop_test_lamp(loop_test_lamp), .print_data(print_data), .modulator_data(modulator_data),
  .spacing_disc_enable(spacing_disc_enable), .break_release_lamp(break_release_lamp),
  .hold_off_lamp(hold_off_lamp), .clear_lamp(clear_lamp), .reply_button_lamp(reply_button_lamp),
  .tx_brk_held(tx_brk_held), .recv_brk_normal_held(recv_brk_normal_held), .line_seized(line_seized));

// ==== tb/terminal_call_control_tb.sv ====
`timescale 1ns/1ps
module terminal_call_control_tb;
  import call_ctrl_pkg::*;
  localparam int CL = 20;
  localparam logic [31:0] P_TEST = 32'h0000_0800, P_BRK = 32'h0000_0200, P_HOLD = 32'h0000_0100,
    P_CLR = 32'h0000_0080, P_ANS = 32'h0000_0040, P_TXH = 32'h0000_0020, P_RXH = 32'h0000_0010,
    P_SEIZ = 32'h0000_0008, P_REP = 32'h0000_0004, P_IDLE = 32'h0000_0403, P_ALL = 32'hFFFF_FFFF;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [5:0]  btn = 6'h00;
  logic [3:0]  inh = 4'h0;
  logic        eot_code = 1'b0;
  logic        ring_req = 1'b0, hold_req = 1'b0, conv_req = 1'b0, rx_bit = 1'b1, tx_data_in = 1'b1;
  logic        ring_in, hold_off_signal, conv_break_in, rx_data_in, pin_req = 1'b0;
  logic        loop_test_lamp, print_data, modulator_data, spacing_disc_enable, break_release_lamp;
  logic        hold_off_lamp, clear_lamp, reply_button_lamp, tx_brk_held, recv_brk_normal_held;
  logic        line_seized, reply_out;
  logic [31:0] seed = 32'h43ee_86a4;
  logic [31:0] exp_q[$], msk_q[$];
  logic [31:0] got, e, m;
  int          err_total = 0, compares = 0;
  wire  [11:0] pins = {loop_test_lamp, spacing_disc_enable, break_release_lamp, hold_off_lamp, clear_lamp,
    reply_button_lamp, tx_brk_held, recv_brk_normal_held, line_seized, reply_out, modulator_data, print_data};

  always #20 mclk = ~mclk;

  terminal_call_control #(.CLEAR_LIMIT(CL), .DEBOUNCE_LIMIT(4)) u_terminal_call_control (
    .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .test_button(btn[0]), .clear_button(btn[1]), .answer_button(btn[2]), .orig_button(btn[3]),
    .local_button(btn[4]), .break_button(btn[5]), .ring_in(ring_in), .hold_off_signal(hold_off_signal),
    .conv_break_in(conv_break_in), .copy_mode(inh[0]), .paper_low(inh[1]), .out_of_service(inh[2]),
    .forms_feed(inh[3]), .eot_code(eot_code), .rx_data_in(rx_data_in), .tx_data_in(tx_data_in),
    .loop_test_lamp(loop_test_lamp), .print_data(print_data), .modulator_data(modulator_data),
    .spacing_disc_enable(spacing_disc_enable), .break_release_lamp(break_release_lamp),
    .hold_off_lamp(hold_off_lamp), .clear_lamp(clear_lamp), .reply_button_lamp(reply_button_lamp),
    .tx_brk_held(tx_brk_held), .recv_brk_normal_held(recv_brk_normal_held), .line_seized(line_seized),
    .reply_out(reply_out));

  coupler_model #(.LAG(2)) u_coupler_model (.mclk(mclk), .ring_req(ring_req), .hold_req(hold_req),
    .conv_req(conv_req), .rx_bit(rx_bit), .ring_in(ring_in), .hold_off_signal(hold_off_signal),
    .conv_break_in(conv_break_in), .rx_data_in(rx_data_in));

  // ------
  // Result watcher
  // ------
  always @(posedge mclk)
    if ((avs_read && avs_waitrequest === 1'b0) || pin_req)
    begin
      got = pin_req ? {20'h0_0000, pins} : avs_readdata;
      compares++;
      if (exp_q.size() == 0)
      begin
        $display("unexpected at %0t: no note", $time);
        err_total++;
      end
      else
      begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        if (((got ^ e) & m) !== 32'h0000_0000)
        begin
          $display("unexpected at %0t: got %h want %h", $time, got, e);
          err_total++;
        end
      end
    end

  // ------
  // Tasks
  // ------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic chk(input logic [31:0] v, input logic [31:0] k);
    exp_q.push_back(v);
    msk_q.push_back(k);
    pin_req <= 1'b1;
    cyc(1);
    pin_req <= 1'b0;
    cyc(1);
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do
    begin
      cyc(1);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      $display("unexpected at %0t: bus answer timeout", $time);
      err_total++;
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    cyc(1);
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] v);
    exp_q.push_back(v);
    msk_q.push_back(P_ALL);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic press(input int i);
    btn[i] <= 1'b1;
    cyc(10);
    btn[i] <= 1'b0;
    cyc(10);
  endtask : press

  // Clear released early; the sequence must run on by itself
  task automatic clr();
    btn[1] <= 1'b1;
    cyc(10);
    btn[1] <= 1'b0;
    cyc(3);
  endtask : clr

  task automatic rst();
    srst <= 1'b1;
    cyc(3);
    srst <= 1'b0;
    cyc(10);
  endtask : rst

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    cyc(8000);
    $display("unexpected at %0t: watchdog", $time);
    err_total++;
    give_verdict();
  end

  // ------
  // Scenarios
  // ------
  initial
  begin
    rst();
    chk(P_IDLE, P_ALL);
    rd(ADDR_CTRL, 32'h0000_0002);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    rd(4'h8, 32'h0000_0000);
    // Held status bits read back high even while variant A is selected
    rd(ADDR_STAT, 32'h0000_00C0);
    btn[0] <= 1'b1;
    cyc(2);
    btn[0] <= 1'b0;
    cyc(14);
    chk(P_IDLE, P_ALL);
    $display("test 0 done");
    for (int i = 1; i < 6; i++)
    begin
      press(0);
      repeat (3)
      begin
        seed = xs(seed);
        rx_bit     <= seed[0];
        tx_data_in <= seed[1];
        cyc(10);
        chk(P_TEST | {30'h0000_0000, rx_bit, rx_bit}, P_ALL);
      end
      rx_bit     <= 1'b1;
      tx_data_in <= 1'b1;
      press(i);
      chk(32'h0000_0400, P_TEST | 32'h0000_0400);
      rst();
    end
    $display("test 1 done");
    hold_req <= 1'b1;
    cyc(14);
    chk(P_IDLE | P_HOLD, P_ALL);
    hold_req <= 1'b0;
    conv_req <= 1'b1;
    cyc(14);
    chk(P_IDLE | P_HOLD | P_BRK, P_ALL);
    conv_req <= 1'b0;
    cyc(14);
    chk(P_IDLE, P_ALL);
    $display("test 2 done");
    for (int i = 0; i < 7; i++)
    begin
      if (i < 4)
        inh[i] <= 1'b1;
      if (i == 4)
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
      if (i > 4)
        press(i == 5 ? 4 : 0);
      ring_req <= 1'b1;
      cyc(14);
      chk(P_ANS, P_ANS | P_SEIZ | P_REP);
      ring_req <= 1'b0;
      inh      <= 4'h0;
      rst();
    end
    $display("test 3 done");
    ring_req <= 1'b1;
    cyc(14);
    chk(P_IDLE | P_ANS | P_SEIZ | P_REP, P_ALL);
    ring_req <= 1'b0;
    cyc(14);
    chk(P_IDLE | P_ANS | P_SEIZ | P_REP, P_ALL);
    clr();
    chk(P_IDLE | P_CLR | P_SEIZ | P_REP, P_ALL);
    rd(ADDR_STAT, 32'h0000_00CE);
    cyc(30);
    chk(P_IDLE, P_ALL);
    press(1);
    chk(P_IDLE, P_ALL);
    // End of transmission starts the timed clear without the key
    ring_req <= 1'b1;
    cyc(14);
    ring_req <= 1'b0;
    cyc(14);
    eot_code <= 1'b1;
    cyc(13);
    eot_code <= 1'b0;
    chk(P_IDLE | P_CLR | P_SEIZ | P_REP, P_ALL);
    cyc(30);
    chk(P_IDLE, P_ALL);
    $display("test 4 done");
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    cyc(4);
    chk(P_IDLE | P_TXH | P_RXH, P_ALL);
    ring_req <= 1'b1;
    cyc(14);
    chk(P_IDLE | P_TXH | P_RXH | P_ANS | P_SEIZ, P_ALL);
    ring_req <= 1'b0;
    cyc(14);
    chk(P_IDLE | P_TXH | P_RXH | P_SEIZ, ~P_ANS);
    clr();
    chk(P_IDLE | P_CLR | P_SEIZ, P_ALL);
    cyc(30);
    chk(P_IDLE | P_TXH | P_RXH, P_ALL);
    $display("test 5 done");
    give_verdict();
  end
endmodule : terminal_call_control_tb
